// ==== core/ser_status_bank.sv ====
// status event register bank: measurement, questionable, operation
`timescale 1ns/1ps
// Function
// - reading an event register clears it in the cycle its value is captured; sets in that cycle survive
// - a query answers with the register value as decimal text
// - measurement bit 0 sets when a reading exceeds the range
// - measurement bits 1 and 2 set on first low and high limit
// - measurement bits 3 and 4 set on second low and high limit
// - measurement bit 5 sets when a reading is taken and processed
// - measurement bit 7 sets when the buffer holds two or more readings
// - measurement bit 8 sets when the buffer is half full
// - measurement bit 9 sets when the buffer is full
// - measurement bit 11 sets when a reading is too small for range
// - measurement bit 12 sets when distortion frequency is too high
// - measurement bit 13 sets when distortion frequency is too low
// - measurement bit 14 sets when frequency suits no shaping filter
// - questionable bit 4 sets on invalid reference junction measurement
// - questionable bit 8 sets on bad calibration constant; use default
// - calibration error clears after successful calibration
// - questionable bit 14 sets when a measurement command parameter is ignored
// - error indicator on while a questionable event stands, off when cleared
// - operation bit 4 sets while measuring
// - operation bit 5 sets while in trigger device action stage
// - operation bit 10 sets while idle
// - enable masks gate each register onto its summary output
module ser_status_bank (
  input wire logic clk,
  input wire logic reset,
  // condition inputs, from same-clock logic
  input wire logic readingOverRange,
  input wire logic belowFirstLowLimit,
  input wire logic aboveFirstHighLimit,
  input wire logic belowSecondLowLimit,
  input wire logic aboveSecondHighLimit,
  input wire logic readingReady,
  input wire logic [15:0] bufferCount,
  input wire logic [15:0] bufferCapacity,
  input wire logic readingUnderRange,
  input wire logic distortionFreqHigh,
  input wire logic distortionFreqLow,
  input wire logic shapingFilterError,
  input wire logic junctionInvalid,
  input wire logic calConstantBad,
  input wire logic calSuccess,
  input wire logic paramIgnored,
  input wire logic measuring,
  input wire logic triggerAction,
  input wire logic idle,
  // enable masks
  input wire logic [15:0] measEnable,
  input wire logic [15:0] quesEnable,
  input wire logic [15:0] operEnable,
  // query port
  input wire logic queryValid,
  input wire logic [1:0] querySel,
  input wire logic talkReady,
  output logic queryBusy,
  output logic charValid,
  output logic [7:0] charData,
  output logic charLast,
  output logic [15:0] queryValue,
  // indicators
  output logic errorIndicator,
  output logic useDefaultCal,
  output logic measSummary,
  output logic quesSummary,
  output logic operSummary
);
  typedef struct packed {
    ser_pkg::ser_state_t state;
    logic [1:0] sel;
    logic [15:0] value;
    logic [19:0] digits;
    logic [2:0] idx;
    logic leading;
    logic [7:0] data;
    logic valid;
    logic last;
    logic errLed;
    logic calDefault;
    logic measSum;
    logic quesSum;
    logic operSum;
    logic busy;
  } ser_top_t;
  ser_top_t r;
  ser_top_t next_r;

  logic [15:0] measSet;
  logic [15:0] quesSet;
  logic [15:0] operSet;
  logic [15:0] quesClear;
  logic [15:0] measVal;
  logic [15:0] quesVal;
  logic [15:0] operVal;
  logic measSumW;
  logic quesSumW;
  logic operSumW;
  logic measRc;
  logic quesRc;
  logic operRc;
  logic convStart;
  logic convDone;
  logic [19:0] convBcd;
  logic [16:0] twiceCount;
  logic [3:0] digit;

  assign twiceCount = {bufferCount, 1'b0};

  always_comb begin
    measSet = 16'h0000;
    measSet[ser_pkg::M_OVER] = readingOverRange;
    measSet[ser_pkg::M_LL1] = belowFirstLowLimit;
    measSet[ser_pkg::M_HL1] = aboveFirstHighLimit;
    measSet[ser_pkg::M_LL2] = belowSecondLowLimit;
    measSet[ser_pkg::M_HL2] = aboveSecondHighLimit;
    measSet[ser_pkg::M_RDY] = readingReady;
    measSet[ser_pkg::M_BAV] = bufferCount >= 16'h0002;
    measSet[ser_pkg::M_BHALF] = (bufferCapacity != 16'h0000) &&
      (twiceCount >= {1'b0, bufferCapacity});
    measSet[ser_pkg::M_BFULL] = (bufferCapacity != 16'h0000) &&
      (bufferCount >= bufferCapacity);
    measSet[ser_pkg::M_UNDER] = readingUnderRange;
    measSet[ser_pkg::M_FHIGH] = distortionFreqHigh;
    measSet[ser_pkg::M_FLOW] = distortionFreqLow;
    measSet[ser_pkg::M_SHAPE] = shapingFilterError;
    quesSet = 16'h0000;
    quesSet[ser_pkg::Q_TEMP] = junctionInvalid;
    quesSet[ser_pkg::Q_CAL] = calConstantBad;
    quesSet[ser_pkg::Q_WARN] = paramIgnored;
    quesClear = 16'h0000;
    quesClear[ser_pkg::Q_CAL] = calSuccess;
    operSet = 16'h0000;
    operSet[ser_pkg::O_MEAS] = measuring;
    operSet[ser_pkg::O_TRIG] = triggerAction;
    operSet[ser_pkg::O_IDLE] = idle;
  end

  // measurement events have no clearing condition besides a read
  ser_event_reg #(
    .USED(ser_pkg::MEAS_USED)
  ) measReg (
    .clk(clk),
    .reset(reset),
    .setBits(measSet),
    .clearBits(16'h0000),
    .readClear(measRc),
    .enableMask(measEnable),
    .value(measVal),
    .summary(measSumW)
  );
  // calibration success clears the calibration bit
  ser_event_reg #(
    .USED(ser_pkg::QUES_USED)
  ) quesReg (
    .clk(clk),
    .reset(reset),
    .setBits(quesSet),
    .clearBits(quesClear),
    .readClear(quesRc),
    .enableMask(quesEnable),
    .value(quesVal),
    .summary(quesSumW)
  );
  // operation events clear only on a read
  ser_event_reg #(
    .USED(ser_pkg::OPER_USED)
  ) operReg (
    .clk(clk),
    .reset(reset),
    .setBits(operSet),
    .clearBits(16'h0000),
    .readClear(operRc),
    .enableMask(operEnable),
    .value(operVal),
    .summary(operSumW)
  );

  ser_dec_conv conv (
    .clk(clk),
    .reset(reset),
    .start(convStart),
    .binIn(r.value),
    .done(convDone),
    .bcd(convBcd)
  );

  // snapshot taken and register cleared in the same cycle; new sets survive
  assign measRc = (r.state == ser_pkg::SER_IDLE) && queryValid &&
    (querySel == ser_pkg::SEL_MEAS);
  assign quesRc = (r.state == ser_pkg::SER_IDLE) && queryValid &&
    (querySel == ser_pkg::SEL_QUES);
  assign operRc = (r.state == ser_pkg::SER_IDLE) && queryValid &&
    (querySel == ser_pkg::SEL_OPER);

  always_comb begin
    next_r = r;
    convStart = 1'b0;
    digit = r.digits[19:16];
    next_r.measSum = measSumW;
    next_r.quesSum = quesSumW;
    next_r.operSum = operSumW;
    next_r.errLed = |quesVal;
    if (calConstantBad) begin
      next_r.calDefault = 1'b1;
    end else if (calSuccess) begin
      next_r.calDefault = 1'b0;
    end
    case (r.state)
      ser_pkg::SER_IDLE: begin
        if (queryValid && querySel != 2'h3) begin
          next_r.sel = querySel;
          case (querySel)
            ser_pkg::SEL_MEAS: next_r.value = measVal;
            ser_pkg::SEL_QUES: next_r.value = quesVal;
            default: next_r.value = operVal;
          endcase
          next_r.state = ser_pkg::SER_CONV;
        end
      end
      ser_pkg::SER_CONV: begin
        // first cycle here starts the converter
        if (r.idx == 3'h0 && !r.leading) begin
          convStart = 1'b1;
          next_r.leading = 1'b1;
        end else if (convDone) begin
          next_r.digits = convBcd;
          next_r.idx = 3'h0;
          next_r.state = ser_pkg::SER_SEND;
        end
      end
      ser_pkg::SER_SEND: begin
        // decimal text, leading zeros dropped, at least one digit
        if (!r.valid || talkReady) begin
          next_r.valid = 1'b0;
          if (r.leading && digit == 4'h0 && r.idx != 3'(ser_pkg::DIGITS - 1)) begin
            next_r.digits = {r.digits[15:0], 4'h0};
            next_r.idx = r.idx + 3'h1;
          end else begin
            next_r.leading = 1'b0;
            next_r.valid = 1'b1;
            next_r.data = ser_pkg::ASCII_ZERO + {4'h0, digit};
            next_r.digits = {r.digits[15:0], 4'h0};
            next_r.idx = r.idx + 3'h1;
            if (r.idx == 3'(ser_pkg::DIGITS - 1)) begin
              next_r.state = ser_pkg::SER_TERM;
            end
          end
        end
      end
      ser_pkg::SER_TERM: begin
        if (talkReady) begin
          if (r.last) begin
            next_r.valid = 1'b0;
            next_r.last = 1'b0;
            next_r.idx = 3'h0;
            next_r.leading = 1'b0;
            next_r.state = ser_pkg::SER_IDLE;
          end else begin
            next_r.data = ser_pkg::ASCII_LF;
            next_r.last = 1'b1;
            next_r.valid = 1'b1;
          end
        end
      end
      default: next_r.state = ser_pkg::SER_IDLE;
    endcase
    // busy flag registered so the port comes straight from a flop
    next_r.busy = next_r.state != ser_pkg::SER_IDLE;
    if (reset) begin
      next_r = '0;
      next_r.state = ser_pkg::SER_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign queryBusy = r.busy;
  assign charValid = r.valid;
  assign charData = r.data;
  assign charLast = r.last;
  assign queryValue = r.value;
  assign errorIndicator = r.errLed;
  assign useDefaultCal = r.calDefault;
  assign measSummary = r.measSum;
  assign quesSummary = r.quesSum;
  assign operSummary = r.operSum;
endmodule : ser_status_bank

// ==== core/ser_pkg.sv ====
// constants for the status event register bank
package ser_pkg;
  localparam int REG_W = 16;
  // register select codes on the query port
  localparam logic [1:0] SEL_MEAS = 2'h0;
  localparam logic [1:0] SEL_QUES = 2'h1;
  localparam logic [1:0] SEL_OPER = 2'h2;
  // measurement event bit positions
  localparam int M_OVER = 0;
  localparam int M_LL1 = 1;
  localparam int M_HL1 = 2;
  localparam int M_LL2 = 3;
  localparam int M_HL2 = 4;
  localparam int M_RDY = 5;
  localparam int M_BAV = 7;
  localparam int M_BHALF = 8;
  localparam int M_BFULL = 9;
  localparam int M_UNDER = 11;
  localparam int M_FHIGH = 12;
  localparam int M_FLOW = 13;
  localparam int M_SHAPE = 14;
  // questionable event bit positions
  localparam int Q_TEMP = 4;
  localparam int Q_CAL = 8;
  localparam int Q_WARN = 14;
  // operation event bit positions
  localparam int O_MEAS = 4;
  localparam int O_TRIG = 5;
  localparam int O_IDLE = 10;
  // implemented bits of each register
  localparam logic [15:0] MEAS_USED = 16'h7bbf;
  localparam logic [15:0] QUES_USED = 16'h4110;
  localparam logic [15:0] OPER_USED = 16'h0430;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  // decimal text: up to five digits
  localparam int DIGITS = 5;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_LF = 8'h0a;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_CONV = 2'b01,
    SER_SEND = 2'b11,
    SER_TERM = 2'b10
  } ser_state_t;
endpackage : ser_pkg

// ==== core/ser_event_reg.sv ====
// one latched event register with read clear and enable mask
`timescale 1ns/1ps
module ser_event_reg #(
  parameter logic [15:0] USED = 16'hffff
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] setBits,
  input wire logic [15:0] clearBits,
  input wire logic readClear,
  input wire logic [15:0] enableMask,
  output logic [15:0] value,
  output logic summary
);
  typedef struct packed {
    logic [15:0] bits;
    logic sum;
  } ser_er_t;
  ser_er_t r;
  ser_er_t next_r;

  always_comb begin
    next_r = r;
    // set wins over clear; unused bits forced to zero
    if (readClear) begin
      next_r.bits = ser_pkg::REG_RESET;
    end
    next_r.bits = (next_r.bits & ~clearBits) | (setBits & USED);
    next_r.sum = |(next_r.bits & enableMask);
    if (reset) begin
      next_r.bits = ser_pkg::REG_RESET;
      next_r.sum = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign value = r.bits;
  assign summary = r.sum;
endmodule : ser_event_reg

// ==== core/ser_dec_conv.sv ====
// 16-bit binary to five decimal digits by sequential double dabble
`timescale 1ns/1ps
module ser_dec_conv (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [15:0] binIn,
  output logic done,
  output logic [19:0] bcd
);
  typedef struct packed {
    logic [15:0] shift;
    logic [19:0] acc;
    logic [4:0] count;
    logic busy;
    logic done;
  } ser_dc_t;
  ser_dc_t r;
  ser_dc_t next_r;
  logic [19:0] adj;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    adj = r.acc;
    for (int i = 0; i < 5; i++) begin
      if (adj[i*4 +: 4] > 4'h4) begin
        adj[i*4 +: 4] = adj[i*4 +: 4] + 4'h3;
      end
    end
    if (start) begin
      next_r.shift = binIn;
      next_r.acc = 20'h00000;
      next_r.count = 5'h10;
      next_r.busy = 1'b1;
    end else if (r.busy) begin
      next_r.acc = {adj[18:0], r.shift[15]};
      next_r.shift = {r.shift[14:0], 1'b0};
      next_r.count = r.count - 5'h01;
      if (r.count == 5'h01) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
    end
    if (reset) begin
      next_r = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign done = r.done;
  assign bcd = r.acc;
endmodule : ser_dec_conv

// ==== test/ser_bank_props.sv ====
// assertions on the status event register bank ports
`timescale 1ns/1ps
module ser_bank_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic junctionInvalid,
  input wire logic calConstantBad,
  input wire logic calSuccess,
  input wire logic idle,
  input wire logic [15:0] quesEnable,
  input wire logic [15:0] operEnable,
  input wire logic queryValid,
  input wire logic [1:0] querySel,
  input wire logic talkReady,
  input wire logic queryBusy,
  input wire logic charValid,
  input wire logic [7:0] charData,
  input wire logic charLast,
  input wire logic [15:0] queryValue,
  input wire logic errorIndicator,
  input wire logic useDefaultCal,
  input wire logic quesSummary,
  input wire logic operSummary
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence sTaken;
    queryValid && !queryBusy && querySel != 2'h3;
  endsequence
  sequence sLastTaken;
    charValid && charLast && talkReady;
  endsequence
  AST_QUERY_TAKEN: assert property (sTaken |=> queryBusy)
    else $error("query not taken");
  AST_SEL_REFUSED: assert property (queryValid && !queryBusy && querySel == 2'h3 |=> !queryBusy)
    else $error("unused select taken");
  AST_CHAR_HOLD: assert property (charValid && !talkReady |=> charValid && $stable(charData))
    else $error("char dropped before accept");
  AST_LAST_IS_LF: assert property (charValid && charLast |-> charData == ser_pkg::ASCII_LF)
    else $error("last char not line feed");
  AST_DIGIT: assert property (charValid && !charLast |-> charData inside {[8'h30:8'h39]})
    else $error("char not a digit");
  AST_END_BUSY: assert property (sLastTaken |=> !queryBusy)
    else $error("busy after line feed");
  AST_QUES_UNUSED: assert property ($rose(queryBusy) && $past(querySel) == ser_pkg::SEL_QUES
      |-> (queryValue & ~ser_pkg::QUES_USED) == 16'h0000)
    else $error("unused bit set");
  AST_ERR_ON: assert property (junctionInvalid |-> ##2 errorIndicator)
    else $error("error indicator late");
  AST_CAL_DEFAULT: assert property (calConstantBad |=> useDefaultCal)
    else $error("default cal not used");
  AST_CAL_CLEAR: assert property (calSuccess && !calConstantBad |=> !useDefaultCal)
    else $error("default cal not cleared");
  AST_QUES_MASKED: assert property (quesEnable == 16'h0000 ##1 quesEnable == 16'h0000 |=> !quesSummary)
    else $error("masked summary set");
  AST_IDLE_SUMMARY: assert property (idle && operEnable[10] ##1 operEnable[10] |=> operSummary)
    else $error("summary missing");
endmodule : ser_bank_props
bind ser_status_bank ser_bank_props u_ser_bank_props (.clk, .reset, .junctionInvalid,
  .calConstantBad, .calSuccess, .idle, .quesEnable, .operEnable, .queryValid, .querySel,
  .talkReady, .queryBusy, .charValid, .charData, .charLast, .queryValue, .errorIndicator,
  .useDefaultCal, .quesSummary, .operSummary);

// ==== test/ser_host_model.sv ====
// host model that takes the decimal answer text
`timescale 1ns/1ps
module ser_host_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic charValid,
  input wire logic [7:0] charData,
  input wire logic charLast,
  output logic talkReady,
  output logic [19:0] gotValue,
  output logic [7:0] nDone
);
  logic [19:0] acc;
  always_ff @(posedge clk) begin
    if (reset) begin
      talkReady <= 1'b0;
      acc <= 20'h00000;
      gotValue <= 20'h00000;
      nDone <= 8'h00;
    end else begin
      // slow host accepts every other cycle
      talkReady <= slow ? ~talkReady : 1'b1;
      if (charValid && talkReady && charLast) begin
        gotValue <= acc;
        acc <= 20'h00000;
        nDone <= nDone + 8'h01;
      end else if (charValid && talkReady) begin
        acc <= acc * 20'h0000a + {12'h000, charData - 8'h30};
      end
    end
  end
endmodule : ser_host_model

// ==== test/testbench.sv ====
// self-checking bench for the status event register bank
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, reset = 1'b1, slow = 1'b0, queryValid = 1'b0, talkReady;
  logic [16:0] cond = '0;
  logic [1:0] querySel = 2'h0;
  logic [15:0] bufferCount = 16'h0000, bufferCapacity = 16'h0008, queryValue;
  logic [15:0] measEnable = 16'h0000, quesEnable = 16'h0000, operEnable = 16'h0400;
  logic queryBusy, charValid, charLast, errorIndicator, useDefaultCal;
  logic measSummary, quesSummary, operSummary;
  logic [7:0] charData, nDone;
  logic [19:0] gotValue;
  int err_count = 0, n_compared = 0;
  int mpos [10] = '{0, 1, 2, 3, 4, 5, 11, 12, 13, 14};
  logic [15:0] bcnt [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0008};
  logic [15:0] bexp [5] = '{16'h0000, 16'h0080, 16'h0080, 16'h0180, 16'h0380};
  int cIdx [5] = '{10, 13, 14, 15, 16};
  logic [1:0] cSel [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
  logic [15:0] cExp [5] = '{16'h0010, 16'h4000, 16'h0010, 16'h0020, 16'h0400};
  always #12.5 clk = ~clk;
  ser_status_bank u_ser_status_bank (.clk, .reset, .readingOverRange(cond[0]),
    .belowFirstLowLimit(cond[1]), .aboveFirstHighLimit(cond[2]), .belowSecondLowLimit(cond[3]),
    .aboveSecondHighLimit(cond[4]), .readingReady(cond[5]), .bufferCount, .bufferCapacity,
    .readingUnderRange(cond[6]), .distortionFreqHigh(cond[7]), .distortionFreqLow(cond[8]),
    .shapingFilterError(cond[9]), .junctionInvalid(cond[10]), .calConstantBad(cond[11]),
    .calSuccess(cond[12]), .paramIgnored(cond[13]), .measuring(cond[14]),
    .triggerAction(cond[15]), .idle(cond[16]), .measEnable, .quesEnable, .operEnable,
    .queryValid, .querySel, .talkReady, .queryBusy, .charValid, .charData, .charLast,
    .queryValue, .errorIndicator, .useDefaultCal, .measSummary, .quesSummary, .operSummary);
  ser_host_model u_ser_host_model (.clk, .reset, .slow, .charValid, .charData, .charLast,
    .talkReady, .gotValue, .nDone);
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask : chk
  task automatic pulse(input int b);
    @(posedge clk);
    cond[b] <= 1'b1;
    @(posedge clk);
    cond[b] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse
  task automatic query(input logic [1:0] sel, input logic [15:0] exp);
    logic [7:0] n0;
    n0 = nDone;
    @(posedge clk);
    queryValid <= 1'b1;
    querySel <= sel;
    @(posedge clk);
    queryValid <= 1'b0;
    for (int i = 0; i < 400 && nDone == n0; i++) begin
      @(posedge clk);
      #1;
    end
    if (nDone == n0) begin
      err_count++;
      wrap_up();
    end
    chk("text", gotValue, {4'h0, exp});
    chk("queryValue", {4'h0, queryValue}, {4'h0, exp});
  endtask : query
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      pulse(i);
      query(2'h0, 16'h0001 << mpos[i]);
    end
    query(2'h0, 16'h0000);
    $display("done: single conditions");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      bufferCount <= bcnt[i];
      @(posedge clk);
      bufferCount <= 16'h0000;
      query(2'h0, bexp[i]);
    end
    $display("done: buffer levels");
    slow <= 1'b1;
    @(posedge clk);
    cond[9:0] <= 10'h3ff;
    bufferCount <= 16'h0008;
    @(posedge clk);
    cond[9:0] <= 10'h000;
    bufferCount <= 16'h0000;
    repeat (3) @(posedge clk);
    query(2'h0, 16'h7bbf);
    $display("done: all bits slow host");
    pulse(10);
    #1;
    chk("errorIndicator", errorIndicator, 1'b1);
    for (int i = 0; i < 5; i++) begin
      pulse(cIdx[i]);
      #1;
      chk("operSummary", operSummary, {19'h0, cIdx[i] == 16});
      query(cSel[i], cExp[i]);
    end
    repeat (2) @(posedge clk);
    #1;
    chk("errorIndicator", errorIndicator, 1'b0);
    $display("done: questionable and operation");
    @(posedge clk);
    quesEnable <= 16'h0100;
    pulse(11);
    #1;
    chk("quesSummary", quesSummary, 1'b1);
    query(2'h1, 16'h0100);
    chk("useDefaultCal", useDefaultCal, 1'b1);
    pulse(11);
    pulse(12);
    query(2'h1, 16'h0000);
    chk("useDefaultCal", useDefaultCal, 1'b0);
    chk("quesSummary", quesSummary, 1'b0);
    $display("done: calibration");
    measEnable <= 16'h0020;
    pulse(5);
    #1;
    chk("measSummary", measSummary, 1'b1);
    @(posedge clk);
    queryValid <= 1'b1;
    querySel <= 2'h3;
    @(posedge clk);
    queryValid <= 1'b0;
    #1;
    chk("queryBusy", queryBusy, 1'b0);
    query(2'h0, 16'h0020);
    $display("done: summary and refusal");
    wrap_up();
  end
endmodule : testbench
